//--- pwm_input_pkg.sv
// Package with register map, field layout and codes of the input conditioning block.
package pwm_input_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [3:0] ctrl_high_addr = 4'h0;
    localparam logic [3:0] blank_low_addr = 4'h4;
    localparam logic [3:0] status_addr = 4'h8;
    localparam logic [15:0] ctrl_high_reset = 16'h0000;
    localparam logic [15:0] blank_low_reset = 16'h0000;
    localparam logic [15:0] ctrl_high_wmask = 16'hf7ff;
    localparam logic [15:0] blank_low_wmask = 16'hfff8;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int bypass_enable_bit = 15;
    localparam int bypass_sel_lsb = 12;
    localparam int accept_lsb = 8;
    localparam int sw_bit_pos = 7;
    localparam int sw_target_lsb = 5;
    localparam int latch_mode_bit = 4;
    localparam int tq_polarity_bit = 3;
    localparam int tq_source_lsb = 0;
    localparam int gen_sel_lsb = 0;
    localparam int input_sel_lsb = 3;
    localparam int blank_shift = 3;

    // ------------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        tq_none = 3'h0, tq_duty = 3'h1, tq_blank = 3'h2, tq_trig = 3'h3,
        tq_src1 = 3'h4, tq_src8 = 3'h5, tq_src9 = 3'h6, tq_sw = 3'h7
    } tq_code_t;
    typedef enum logic [2:0] {
        acc_level = 3'h0, acc_rise = 3'h1, acc_any = 3'h2,
        acc_latch = 3'h3, acc_latch_rise = 3'h4, acc_latch_any = 3'h5
    } acc_code_t;
    localparam logic [1:0] sw_to_input = 2'h0;
    localparam logic [1:0] sw_to_accept = 2'h1;
    localparam logic [1:0] sw_to_qual = 2'h2;
    localparam logic [4:0] src_sel_zero = 5'h00;
    localparam logic [4:0] src_sel_gen = 5'h01;
    localparam int num_generators = 4;

endpackage : pwm_input_pkg

//--- blank_timer.sv
// Leading-edge blanking counter with eight-clock resolution.
`timescale 1ns/1ps
module blank_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [12:0] period_i,
    output logic active_o
);
    import pwm_input_pkg::*;

    logic [15:0] count;
    logic running;

    // Counting down to zero plus one more clock gives eight clocks per step,
    // so a zero field still blanks for eight.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= 16'h0000;
            running <= 1'b0;
        end else if (start_i) begin
            count <= {period_i, 3'h7};
            running <= 1'b1;
        end else if (count != 16'h0000) begin
            count <= count - 16'h0001;
        end else begin
            running <= 1'b0;
        end
    end

    assign active_o = running;

    blank_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
        start_i && period_i == 13'h0000 ##1 !start_i [*8] |=> !active_o)
        else $error("Blanking too long.");
    blank_min_a: assert property (@(posedge clk_i) disable iff (rst_i)
        start_i |=> active_o [*8])
        else $error("Blanking shorter than eight clocks.");

endmodule : blank_timer

//--- pwm_input_qualify.sv
// Input path conditioning: qualifier select, acceptance, bypass and blanking.
`timescale 1ns/1ps
// How it works
// - Qualifier source code 000 holds the qualifier at one.
// - Code 111 forces hardware qualifier zero; only polarity and software bit remain.
// - Codes 110 and 101 route input sources 9 and 8.
// - Code 100 routes source 1, the selected generator output.
// - Codes 011, 010, 001 use triggered, blanking active, duty active.
// - Blanking period ignores its low three bits; steps of eight.
// - Blanking lasts at least eight clocks when the upper field is zero.
// - Low three blanking bits are read-only and read zero.
// - A missing generator selected for bypass or qualifier gives zero.
// - Reset clears every writable field of both registers.
// - Generator select codes 000 to 011 pick generators one to four.
// - Input source 00000 is zero, 00001 the generator multiplexer.
module pwm_input_qualify #(
    parameter int gen_present = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [pwm_input_pkg::num_generators-1:0] gen_out_i,
    input wire logic [pwm_input_pkg::num_generators-1:0] gen_accept_i,
    input wire logic src8_i,
    input wire logic src9_i,
    input wire logic [3:0] aux_src_i,
    input wire logic duty_active_i,
    input wire logic triggered_i,
    input wire logic blank_start_i,
    input wire logic latch_reset_i,
    output logic accepted_o,
    output logic qualifier_o,
    output logic blank_active_o
);
    import pwm_input_pkg::*;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [15:0] ctrl_high;
    logic [15:0] blank_low;
    logic [4:0] misc;
    logic wr_stb;
    logic rd_hit;

    assign wr_stb = cyc_i && stb_i && we_i && !ack_o;

    // Unimplemented bits never store, so they read zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_high <= ctrl_high_reset;
            blank_low <= blank_low_reset;
            misc <= 5'h00;
        end else if (wr_stb) begin
            if (adr_i == ctrl_high_addr) begin
                if (sel_i[0]) begin
                    ctrl_high[7:0] <= dat_i[7:0] & ctrl_high_wmask[7:0];
                end
                if (sel_i[1]) begin
                    ctrl_high[15:8] <= dat_i[15:8] & ctrl_high_wmask[15:8];
                end
            end
            if (adr_i == blank_low_addr) begin
                if (sel_i[0]) begin
                    blank_low[7:0] <= dat_i[7:0] & blank_low_wmask[7:0];
                end
                if (sel_i[1]) begin
                    blank_low[15:8] <= dat_i[15:8] & blank_low_wmask[15:8];
                end
            end
            if (adr_i == status_addr && sel_i[0]) begin
                misc <= dat_i[4:0];
            end
        end
    end

    // Ack is held one cycle, then dropped so back-to-back cycles separate.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
        end
    end

    assign rd_hit = cyc_i && stb_i && !we_i && !ack_o;

    // ------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------
    logic bypass_enable;
    logic [2:0] bypass_source_select;
    logic [2:0] acceptance_criteria;
    logic software_input_bit;
    logic [1:0] software_input_target;
    logic latch_priority_mode;
    logic term_qualifier_polarity;
    logic [2:0] term_qualifier_source;
    logic [2:0] generator_for_input_select;
    logic [1:0] input_source_select;

    assign bypass_enable = ctrl_high[bypass_enable_bit];
    assign bypass_source_select = ctrl_high[bypass_sel_lsb +: 3];
    assign acceptance_criteria = ctrl_high[accept_lsb +: 3];
    assign software_input_bit = ctrl_high[sw_bit_pos];
    assign software_input_target = ctrl_high[sw_target_lsb +: 2];
    assign latch_priority_mode = ctrl_high[latch_mode_bit];
    assign term_qualifier_polarity = ctrl_high[tq_polarity_bit];
    assign term_qualifier_source = ctrl_high[tq_source_lsb +: 3];
    assign generator_for_input_select = misc[gen_sel_lsb +: 3];
    assign input_source_select = misc[input_sel_lsb +: 2];

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic [1:0] src_meta;
    logic [1:0] src_sync;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
            src_meta <= 2'h0;
            src_sync <= 2'h0;
        end else begin
            pin_meta <= aux_src_i;
            pin_sync <= pin_meta;
            src_meta <= {src9_i, src8_i};
            src_sync <= src_meta;
        end
    end

    // ------------------------------------------------------------------
    // Generator multiplexers
    // ------------------------------------------------------------------
    logic [7:0] gen_avail;
    logic [7:0] acc_avail;

    // Absent or reserved generators read as zero.
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : gen_mux
            if (g < gen_present && g < num_generators) begin : present
                assign gen_avail[g] = gen_out_i[g];
                assign acc_avail[g] = gen_accept_i[g];
            end else begin : absent
                assign gen_avail[g] = 1'b0;
                assign acc_avail[g] = 1'b0;
            end
        end
    endgenerate

    logic gen_mux_out;
    assign gen_mux_out = gen_avail[generator_for_input_select];

    // ------------------------------------------------------------------
    // Input source
    // ------------------------------------------------------------------
    logic raw_input;

    always_comb begin
        case (input_source_select)
            src_sel_zero[1:0]: raw_input = 1'b0;
            src_sel_gen[1:0]: raw_input = gen_mux_out;
            default: raw_input = pin_sync[input_source_select];
        endcase
        if (software_input_target == sw_to_input) begin
            raw_input = raw_input | software_input_bit;
        end
    end

    // ------------------------------------------------------------------
    // Termination qualifier
    // ------------------------------------------------------------------
    logic hw_qual;
    logic qual_pol;
    logic sw_qual;

    always_comb begin
        case (tq_code_t'(term_qualifier_source))
            tq_none: hw_qual = 1'b1;
            tq_duty: hw_qual = duty_active_i;
            tq_blank: hw_qual = blank_active_o;
            tq_trig: hw_qual = triggered_i;
            tq_src1: hw_qual = gen_mux_out;
            tq_src8: hw_qual = src_sync[0];
            tq_src9: hw_qual = src_sync[1];
            tq_sw: hw_qual = 1'b0;
            default: hw_qual = 1'b0;
        endcase
    end

    // The none code bypasses polarity so the qualifier really stays one.
    assign sw_qual = (software_input_target == sw_to_qual) &&
        software_input_bit;
    assign qual_pol = (term_qualifier_source == tq_none) ? 1'b1 :
        ((hw_qual ^ term_qualifier_polarity) | sw_qual);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            qualifier_o <= 1'b0;
        end else begin
            qualifier_o <= qual_pol;
        end
    end

    // ------------------------------------------------------------------
    // Acceptance
    // ------------------------------------------------------------------
    logic in_q;
    logic latched;
    logic rise;
    logic edge_any;
    logic event_in;
    logic local_acc;

    assign rise = raw_input && !in_q;
    assign edge_any = raw_input ^ in_q;

    always_comb begin
        case (acceptance_criteria)
            acc_level, acc_latch: event_in = raw_input;
            acc_rise, acc_latch_rise: event_in = rise;
            acc_any, acc_latch_any: event_in = edge_any;
            default: event_in = 1'b0;
        endcase
        if (software_input_target == sw_to_accept) begin
            event_in = event_in | software_input_bit;
        end
    end

    // Latch: mode bit chooses whether set or reset dominates.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_q <= 1'b0;
            latched <= 1'b0;
        end else begin
            in_q <= raw_input;
            if (event_in && latch_reset_i) begin
                latched <= !latch_priority_mode;
            end else if (event_in) begin
                latched <= 1'b1;
            end else if (latch_reset_i) begin
                latched <= 1'b0;
            end
        end
    end

    // Reserved codes pass only the software bit aimed at acceptance, even with the latch left set.
    assign local_acc = (acceptance_criteria >= acc_latch &&
        acceptance_criteria <= acc_latch_any) ? latched : event_in;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            accepted_o <= 1'b0;
        end else if (bypass_enable) begin
            accepted_o <= acc_avail[bypass_source_select];
        end else begin
            accepted_o <= local_acc && qual_pol;
        end
    end

    // ------------------------------------------------------------------
    // Blanking
    // ------------------------------------------------------------------
    blank_timer u_blank (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(blank_start_i),
        .period_i(blank_low[15:blank_shift]),
        .active_o(blank_active_o)
    );

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h00000000;
        end else if (rd_hit) begin
            case (adr_i)
                ctrl_high_addr: dat_o <= {16'h0000, ctrl_high};
                blank_low_addr: dat_o <= {16'h0000, blank_low};
                status_addr: dat_o <= {25'h0000000, qualifier_o,
                    accepted_o, misc};
                default: dat_o <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    none_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
        term_qualifier_source == tq_none && $stable(term_qualifier_source)
        |=> qualifier_o)
        else $error("Qualifier not one.");
    sw_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
        term_qualifier_source == tq_sw && !sw_qual &&
        !term_qualifier_polarity |=> !qualifier_o)
        else $error("Qualifier not forced.");
    blank_bits_a: assert property (@(posedge clk_i)
        blank_low[2:0] == 3'h0)
        else $error("Blank low bits set.");
    reset_clr_a: assert property (@(posedge clk_i)
        rst_i |=> ctrl_high == 16'h0000 && blank_low == 16'h0000)
        else $error("Reset not cleared.");
    dur_qual_a: assert property (@(posedge clk_i) disable iff (rst_i)
        term_qualifier_source == tq_duty && !term_qualifier_polarity &&
        !sw_qual |=> qualifier_o == $past(duty_active_i))
        else $error("Duty qualifier wrong.");
    bypass_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        bypass_enable && bypass_source_select >= 3'(gen_present)
        |=> !accepted_o)
        else $error("Absent generator not zero.");
    src_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        input_source_select == 2'h0 && software_input_target != sw_to_input
        && software_input_target != sw_to_accept
        && acceptance_criteria == acc_level && !bypass_enable
        |=> !accepted_o)
        else $error("Zero source accepted.");
    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("Ack longer than one cycle.");
    bypass_c: cover property (@(posedge clk_i) bypass_enable && accepted_o);
    latch_c: cover property (@(posedge clk_i) latched && latch_reset_i);
    blank_c: cover property (@(posedge clk_i) blank_active_o && qualifier_o);
    swq_c: cover property (@(posedge clk_i) sw_qual && qualifier_o);

endmodule : pwm_input_qualify

//--- trip_source_model.sv
// Model of the external trip pins that feed input sources eight and nine.
`timescale 1ns/1ps
module trip_source_model (
    input wire logic clk_i,
    input wire logic trip8_req_i,
    input wire logic trip9_req_i,
    output logic src8_o,
    output logic src9_o
);
    // ------------------------------------------------------------------
    // Pin behaviour
    // ------------------------------------------------------------------
    // Comparators are not aligned to the clock, so edges land mid-cycle.
    initial begin
        src8_o = 1'b0;
        src9_o = 1'b0;
        forever begin
            @(posedge clk_i);
            src8_o <= #3 trip8_req_i;
            src9_o <= #4 trip9_req_i;
        end
    end
endmodule : trip_source_model

//--- tb_top.sv
// Self-checking bench for the input conditioning block.
`timescale 1ns/1ps
module tb_top;
    import pwm_input_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [31:0] dat = 32'h0, dat_o, r;
    logic ack_o, accepted_o, qualifier_o, blank_active_o, src8, src9;
    logic [3:0] gen_out = 4'h0, gen_acc = 4'h0;
    logic trip8 = 1'b0, trip9 = 1'b0, duty = 1'b0, trig = 1'b0;
    logic bstart = 1'b0, lreset = 1'b0;
    logic [3:0] aux = 4'h0;
    int fails = 0, n_compared = 0, cycles = 0, cnt;

    // ------------------------------------------------------------------
    // Clock, design and far side
    // ------------------------------------------------------------------
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // Generator four is left out so that a missing generator is reachable.
    pwm_input_qualify #(.gen_present(3)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o),
        .ack_o(ack_o), .gen_out_i(gen_out), .gen_accept_i(gen_acc),
        .src8_i(src8), .src9_i(src9), .aux_src_i(aux),
        .duty_active_i(duty), .triggered_i(trig),
        .blank_start_i(bstart), .latch_reset_i(lreset),
        .accepted_o(accepted_o), .qualifier_o(qualifier_o),
        .blank_active_o(blank_active_o)
    );
    trip_source_model u_trip (
        .clk_i(clk_i), .trip8_req_i(trip8), .trip9_req_i(trip9),
        .src8_o(src8), .src9_o(src9)
    );

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic final_report();
        if (fails == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] rd);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'h3;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic pulse(input logic to_latch);
        @(posedge clk_i);
        if (to_latch) begin
            lreset <= 1'b1;
        end else begin
            bstart <= 1'b1;
        end
        @(posedge clk_i);
        lreset <= 1'b0;
        bstart <= 1'b0;
    endtask : pulse

    // Drives every qualifier source to one level; a high level also
    // starts blanking so that the blanking source reads high too.
    task automatic sources(input logic v);
        @(posedge clk_i);
        gen_out <= {4{v}};
        trig <= v;
        duty <= v;
        trip8 <= v;
        trip9 <= v;
        if (v) begin
            pulse(1'b0);
        end
        repeat (6) @(posedge clk_i);
    endtask : sources

    task automatic blank_len(input logic [15:0] p, input int exp);
        wb(1'b1, blank_low_addr, {16'h0, p}, r);
        pulse(1'b0);
        cnt = 0;
        repeat (300) begin
            @(posedge clk_i);
            if (blank_active_o === 1'b1) begin
                cnt++;
            end
        end
        chk(cnt, exp);
    endtask : blank_len

    // ------------------------------------------------------------------
    // Timeout
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles >= 20000) begin
            fails++;
            final_report();
        end
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, ctrl_high_addr, 32'h0, r);
        chk(r, 32'h0);
        wb(1'b0, blank_low_addr, 32'h0, r);
        chk(r, 32'h0);
        wb(1'b1, ctrl_high_addr, 32'hffff, r);
        wb(1'b0, ctrl_high_addr, 32'h0, r);
        chk(r, {16'h0, ctrl_high_wmask});
        wb(1'b1, blank_low_addr, 32'hffff, r);
        wb(1'b0, blank_low_addr, 32'h0, r);
        chk(r, 32'hfff8);
        wb(1'b0, 4'hc, 32'h0, r);
        chk(r, 32'h0);
        blank_len(16'h0007, 8);
        blank_len(16'h0017, 24);
        wb(1'b1, status_addr, 32'h0, r);
        for (int c = 0; c < 8; c++) begin
            wb(1'b1, ctrl_high_addr, c, r);
            repeat (30) @(posedge clk_i);
            for (int v = 0; v < 2; v++) begin
                sources(v[0]);
                chk(qualifier_o, c == 0 ? 1 : (c == 7 ? 0 : v));
            end
        end
        wb(1'b1, status_addr, 32'h3, r);
        wb(1'b1, ctrl_high_addr, 32'h4, r);
        sources(1'b1);
        chk(qualifier_o, 0);
        wb(1'b1, ctrl_high_addr, 32'hc7, r);
        repeat (4) @(posedge clk_i);
        chk(qualifier_o, 1);
        sources(1'b0);
        wb(1'b1, ctrl_high_addr, 32'h9, r);
        repeat (4) @(posedge clk_i);
        chk(qualifier_o, 1);
        wb(1'b1, ctrl_high_addr, 32'h0, r);
        wb(1'b1, status_addr, 32'h08, r);
        gen_out <= 4'h1;
        repeat (4) @(posedge clk_i);
        chk(accepted_o, 1);
        wb(1'b1, status_addr, 32'h09, r);
        repeat (4) @(posedge clk_i);
        chk(accepted_o, 0);
        wb(1'b1, status_addr, 32'h00, r);
        repeat (4) @(posedge clk_i);
        chk(accepted_o, 0);
        aux <= 4'h8;
        wb(1'b1, status_addr, 32'h18, r);
        repeat (4) @(posedge clk_i);
        chk(accepted_o, 1);
        wb(1'b1, status_addr, 32'h08, r);
        wb(1'b1, ctrl_high_addr, 32'h0300, r);
        repeat (4) @(posedge clk_i);
        gen_out <= 4'h0;
        repeat (4) @(posedge clk_i);
        chk(accepted_o, 1);
        pulse(1'b1);
        repeat (4) @(posedge clk_i);
        chk(accepted_o, 0);
        wb(1'b1, ctrl_high_addr, 32'h0100, r);
        repeat (2) @(posedge clk_i);
        gen_out <= 4'h1;
        @(posedge clk_i);
        chk(accepted_o, 0);
        @(posedge clk_i);
        chk(accepted_o, 1);
        @(posedge clk_i);
        chk(accepted_o, 0);
        wb(1'b1, ctrl_high_addr, 32'h0600, r);
        repeat (4) @(posedge clk_i);
        chk(accepted_o, 0);
        gen_acc <= 4'h2;
        wb(1'b1, ctrl_high_addr, 32'h9000, r);
        repeat (4) @(posedge clk_i);
        chk(accepted_o, 1);
        gen_acc <= 4'h0;
        repeat (4) @(posedge clk_i);
        chk(accepted_o, 0);
        gen_acc <= 4'hf;
        wb(1'b1, ctrl_high_addr, 32'hb000, r);
        repeat (4) @(posedge clk_i);
        chk(accepted_o, 0);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, ctrl_high_addr, 32'h0, r);
        chk(r, 32'h0);
        wb(1'b0, blank_low_addr, 32'h0, r);
        chk(r, 32'h0);
        chk(accepted_o, 0);
        chk(qualifier_o, 1);
        final_report();
    end
endmodule : tb_top
